/* hw/mswt_regs.svh */
/*
  register offsets, reset values and field positions of the upper
  wave table block.
  assumes: included by bare name from every file that needs it.
*/
`ifndef MSWT_REGS_SVH
`define MSWT_REGS_SVH

// ==========================================================
// register offsets
`define MSWT_ADDR_WORD5  8'h65
`define MSWT_ADDR_WORD6  8'h66
`define MSWT_ADDR_WORD7  8'h67
`define MSWT_ADDR_COIL   8'h70

// ==========================================================
// reset values, sine wave table
`define MSWT_RST_WORD5   32'hb5bb777d
`define MSWT_RST_WORD6   32'h49295556
`define MSWT_RST_WORD7   32'h00404222

// ==========================================================
// segment select configuration fields
`define MSWT_SEL_W0      1:0
`define MSWT_SEL_X1      15:8
`define MSWT_SEL_X2      23:16
`define MSWT_SEL_X3      31:24

// ==========================================================
// counter layout: bit that marks odd quarters, quarter offset
`define MSWT_QTR_BIT     8
`define MSWT_QUARTER     10'h100
`define MSWT_ONE         10'h001
`define MSWT_POS_ZERO    10'h000

`endif

/* hw/mswt_pkg.sv */
/*
  types shared by the upper wave table block.
  assumes: nothing beyond the register header.
*/
package mswt_pkg;

  localparam int CNT_W = 10;
  localparam int MAG_W = 9;
  localparam int CUR_W = 10;

  typedef logic [MAG_W-1:0]        mswt_mag_t;
  typedef logic signed [CUR_W-1:0] mswt_cur_t;
  typedef logic signed [3:0]       mswt_delta_t;

  typedef struct packed {
    logic [31:0] word5;
    logic [31:0] word6;
    logic [31:0] word7;
    logic [31:0] rdata;
    mswt_mag_t   mag_a;
    mswt_mag_t   mag_b;
    mswt_cur_t   coil_a_current_value;
    mswt_cur_t   coil_b_current_value;
  } mswt_state_s;

endpackage : mswt_pkg

/* hw/mswt_dec_if.sv */
/*
  lookup request between the wave table core and a decoder.
  assumes: the core drives idx, the decoder answers combinationally.
*/
`timescale 1ns/1ps
interface mswt_dec_if;
  logic [7:0]            idx;
  logic                  tbit;
  logic [1:0]            width;
  mswt_pkg::mswt_delta_t delta;

  modport req (output idx, input tbit, width, delta);
  modport dec (input idx, output tbit, width, delta);
endinterface : mswt_dec_if

/* hw/mswt_decode.sv */
/*
  decodes one table entry into a signed increment.
  assumes: borders satisfy 0 < first < second < third.
*/
`timescale 1ns/1ps
`include "mswt_regs.svh"
module mswt_decode (
  // lookup
  mswt_dec_if.dec           lk,
  // table and segment setup
  input  wire logic [255:0] table_in,
  input  wire logic [31:0]  sel_in
);

  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] b3;
  logic [1:0] seg;
  logic [7:0] wcodes;

  assign b1     = sel_in[`MSWT_SEL_X1];
  assign b2     = sel_in[`MSWT_SEL_X2];
  assign b3     = sel_in[`MSWT_SEL_X3];
  assign wcodes = sel_in[7:0];

  // ==========================================================
  // segment and width code
  always_comb begin
    if (lk.idx >= b3) begin
      seg = 2'h3;
    end else if (lk.idx >= b2) begin
      seg = 2'h2;
    end else if (lk.idx >= b1) begin
      seg = 2'h1;
    end else begin
      seg = 2'h0;
    end
  end

  assign lk.width = wcodes[{seg, 1'b0} +: 2];
  assign lk.tbit  = table_in[lk.idx];
  // code 00 with bit 0 gives -1, each code step and the bit add one
  assign lk.delta = $signed({2'h0, lk.width}) + $signed({3'h0, lk.tbit})
                    - 4'sh1;

endmodule : mswt_decode

/* hw/mswt_upper.sv */
/*
  upper wave table words and the coil current accumulators.
  assumes: counter, lower table words, segment setup and start values
  come from logic on the same clock; step_in is one cycle per microstep
  and microstep_counter_in shows the position before that step.
*/
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "mswt_regs.svh"

// How it works
// - each table bit is the increment from entry k to entry k plus one.
// - bit and width code decode to -1..+2 for zero, +0..+3 for one.
// - word at 0x65 holds increments of entries 160 to 191.
// - word at 0x66 holds increments of entries 192 to 223.
// - word at 0x67 holds increments of entries 224 to 255.
// - table is one quarter wave; other quarters mirror and negate it.
// - at position zero both coils take the stored start values.
// - after reset the words hold the default sine table.
// - four segments split by three borders, each with its width code.
// - passing position zero reloads both start values.
module mswt_upper (
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  // register port
  input  wire logic [7:0]             reg_addr_in,
  input  wire logic [31:0]            reg_wdata_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  output logic [31:0]                 reg_rdata_out,
  // neighbouring table and setup
  input  wire logic [159:0]           lower_table_in,
  input  wire logic [31:0]            segment_select_config_in,
  input  wire logic [7:0]             initial_sine_value_in,
  input  wire logic [7:0]             initial_cosine_value_in,
  // microstep counter
  input  wire logic [9:0]             microstep_counter_in,
  input  wire logic                   step_in,
  input  wire logic                   step_dir_in,
  // coil currents
  output mswt_pkg::mswt_cur_t         coil_a_current_value_out,
  output mswt_pkg::mswt_cur_t         coil_b_current_value_out
);

  mswt_pkg::mswt_state_s s_q;
  mswt_pkg::mswt_state_s s_d;

  logic [255:0] table_bits;
  logic [9:0]   edge_a;
  logic [9:0]   edge_b;
  logic [9:0]   pos_nx;
  logic [9:0]   pos_nx_b;
  logic         rise_a;
  logic         rise_b;

  mswt_dec_if dec_a ();
  mswt_dec_if dec_b ();

  // ==========================================================
  // table assembly and decoders
  assign table_bits = {s_q.word7, s_q.word6, s_q.word5,
                       lower_table_in};

  mswt_decode u_dec_a (
    .lk       (dec_a),
    .table_in (table_bits),
    .sel_in   (segment_select_config_in)
  );

  mswt_decode u_dec_b (
    .lk       (dec_b),
    .table_in (table_bits),
    .sel_in   (segment_select_config_in)
  );

  // ==========================================================
  // position arithmetic
  // the edge is the table step crossed: the old position going up,
  // one below it going down
  assign edge_a   = step_dir_in ? microstep_counter_in
                                : microstep_counter_in - `MSWT_ONE;
  assign edge_b   = edge_a + `MSWT_QUARTER;
  assign pos_nx   = step_dir_in ? microstep_counter_in + `MSWT_ONE
                                : microstep_counter_in - `MSWT_ONE;
  assign pos_nx_b = pos_nx + `MSWT_QUARTER;

  // odd quarters walk the table backwards
  assign dec_a.idx = edge_a[`MSWT_QTR_BIT] ? ~edge_a[7:0]
                                           : edge_a[7:0];
  assign dec_b.idx = edge_b[`MSWT_QTR_BIT] ? ~edge_b[7:0]
                                           : edge_b[7:0];
  assign rise_a = (edge_a[`MSWT_QTR_BIT] == 1'b0) == step_dir_in;
  assign rise_b = (edge_b[`MSWT_QTR_BIT] == 1'b0) == step_dir_in;

  function automatic mswt_pkg::mswt_mag_t step_mag(
    input mswt_pkg::mswt_mag_t   mag,
    input mswt_pkg::mswt_delta_t delta,
    input logic                  rise
  );
    logic signed [10:0] sum;
    sum = $signed({2'h0, mag});
    if (rise) begin
      sum = sum + 11'(delta);
    end else begin
      sum = sum - 11'(delta);
    end
    return sum[8:0];
  endfunction : step_mag

  function automatic mswt_pkg::mswt_cur_t signed_cur(
    input mswt_pkg::mswt_mag_t mag,
    input logic                neg
  );
    mswt_pkg::mswt_cur_t v;
    v = $signed({1'b0, mag});
    if (neg) begin
      v = -v;
    end
    return v;
  endfunction : signed_cur

  // ==========================================================
  // next state
  always_comb begin
    s_d       = s_q;
    s_d.rdata = 32'h0;
    if (reg_wr_in) begin
      case (reg_addr_in)
        `MSWT_ADDR_WORD5: s_d.word5 = reg_wdata_in;
        `MSWT_ADDR_WORD6: s_d.word6 = reg_wdata_in;
        `MSWT_ADDR_WORD7: s_d.word7 = reg_wdata_in;
        default:          s_d.word5 = s_q.word5;
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        `MSWT_ADDR_WORD5: s_d.rdata = s_q.word5;
        `MSWT_ADDR_WORD6: s_d.rdata = s_q.word6;
        `MSWT_ADDR_WORD7: s_d.rdata = s_q.word7;
        `MSWT_ADDR_COIL:  s_d.rdata = {6'h0, s_q.coil_b_current_value, 6'h0, s_q.coil_a_current_value};
        default:          s_d.rdata = 32'h0;
      endcase
    end
    if (step_in) begin
      if (pos_nx == `MSWT_POS_ZERO) begin
        s_d.mag_a = {1'b0, initial_sine_value_in};
        s_d.mag_b = {1'b0, initial_cosine_value_in};
      end else begin
        s_d.mag_a = step_mag(s_q.mag_a, dec_a.delta, rise_a);
        s_d.mag_b = step_mag(s_q.mag_b, dec_b.delta, rise_b);
      end
      s_d.coil_a_current_value = signed_cur(s_d.mag_a, pos_nx[9]);
      s_d.coil_b_current_value = signed_cur(s_d.mag_b, pos_nx_b[9]);
    end else if (microstep_counter_in == `MSWT_POS_ZERO) begin
      s_d.mag_a = {1'b0, initial_sine_value_in};
      s_d.mag_b = {1'b0, initial_cosine_value_in};
      s_d.coil_a_current_value = signed_cur(s_d.mag_a, 1'b0);
      s_d.coil_b_current_value = signed_cur(s_d.mag_b, 1'b0);
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_q       <= '0;
      s_q.word5 <= `MSWT_RST_WORD5;
      s_q.word6 <= `MSWT_RST_WORD6;
      s_q.word7 <= `MSWT_RST_WORD7;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_out            = s_q.rdata;
  assign coil_a_current_value_out = s_q.coil_a_current_value;
  assign coil_b_current_value_out = s_q.coil_b_current_value;

  // ==========================================================
  // checks
  reset_table_a : assert property (
    @(posedge clk_in) $past(rst_in) |->
      (s_q.word5 == `MSWT_RST_WORD5) && (s_q.word6 == `MSWT_RST_WORD6)
      && (s_q.word7 == `MSWT_RST_WORD7))
    else $error("table words not at sine default after reset");

  write_word5_a : assert property (
    @(posedge clk_in) disable iff (rst_in)
    reg_wr_in && reg_addr_in == `MSWT_ADDR_WORD5 ##1 reg_rd_in
      && reg_addr_in == `MSWT_ADDR_WORD5 |=>
      reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("word five does not read back what was written");

  write_word6_a : assert property (
    @(posedge clk_in) disable iff (rst_in)
    reg_wr_in && reg_addr_in == `MSWT_ADDR_WORD6 |=>
      table_bits[223:192] == $past(reg_wdata_in))
    else $error("word six not mapped to entries 192 to 223");

  write_word7_a : assert property (
    @(posedge clk_in) disable iff (rst_in)
    reg_wr_in && reg_addr_in == `MSWT_ADDR_WORD7 |=>
      table_bits[255:224] == $past(reg_wdata_in))
    else $error("word seven not mapped to entries 224 to 255");

  decode_low_a : assert property (
    @(posedge clk_in) disable iff (rst_in)
    dec_a.width == 2'h0 && !dec_a.tbit |-> dec_a.delta == -4'sh1)
    else $error("code 00 with a zero bit must decode to -1");

  decode_high_a : assert property (
    @(posedge clk_in) disable iff (rst_in)
    dec_b.width == 2'h3 && dec_b.tbit |-> dec_b.delta == 4'sh3)
    else $error("code 11 with a one bit must decode to +3");

  entry_bit_a : assert property (
    @(posedge clk_in) disable iff (rst_in)
    dec_b.idx >= 8'he0 |-> dec_b.tbit == s_q.word7[dec_b.idx[4:0]])
    else $error("table bit taken from the wrong position");

  segment_code_a : assert property (
    @(posedge clk_in) disable iff (rst_in)
    dec_a.idx < segment_select_config_in[`MSWT_SEL_X1] |->
      dec_a.width == segment_select_config_in[`MSWT_SEL_W0])
    else $error("first segment does not use its own width code");

  zero_reload_a : assert property (
    @(posedge clk_in) disable iff (rst_in)
    step_in && pos_nx == `MSWT_POS_ZERO |=>
      s_q.mag_a == {1'b0, $past(initial_sine_value_in)}
      && s_q.mag_b == {1'b0, $past(initial_cosine_value_in)})
    else $error("start values not loaded on passing position zero");

  step_rise_a : assert property (
    @(posedge clk_in) disable iff (rst_in)
    step_in && rise_a && pos_nx != `MSWT_POS_ZERO |=>
      s_q.mag_a == $past(s_q.mag_a) + 9'($past(dec_a.delta)))
    else $error("rising step did not add the decoded increment");

  hold_idle_a : assert property (
    @(posedge clk_in) disable iff (rst_in)
    !step_in && microstep_counter_in != `MSWT_POS_ZERO |=>
      $stable(s_q.mag_a) && $stable(coil_b_current_value_out))
    else $error("coil values moved without a step");

  half_sign_a : assert property (
    @(posedge clk_in) disable iff (rst_in)
    step_in && pos_nx[9] && s_d.mag_a != '0 |=>
      coil_a_current_value_out < 0)
    else $error("second half period must drive coil a negative");

endmodule : mswt_upper

/* bench/mswt_tb.sv */
/*
  self-checking bench for the upper wave table block: register reset,
  read/write, refused accesses, position zero load and single steps.
  assumes: the register header, package, interface and design files
  are compiled first; one 25 MHz clock, synchronous reset.
*/
`timescale 1ns/1ps
`include "mswt_regs.svh"
module testbench;
  // ==========================================================
  // signals
  logic                clk_in;
  logic                rst_in;
  logic [7:0]          reg_addr_in;
  logic [31:0]         reg_wdata_in;
  logic                reg_wr_in;
  logic                reg_rd_in;
  logic [31:0]         reg_rdata_out;
  logic [159:0]        lower_table_in;
  logic [31:0]         sel_in;
  logic [7:0]          sin_in;
  logic [7:0]          cos_in;
  logic [9:0]          cnt_in;
  logic                step_in;
  logic                dir_in;
  mswt_pkg::mswt_cur_t coil_a;
  mswt_pkg::mswt_cur_t coil_b;
  int                  fails;
  int                  check_count;
  int                  cycles;

  typedef struct {
    logic [1:0] w_lo;
    logic [1:0] w_hi;
    logic       b_lo;
    logic       b_hi;
    logic       dir;
  } mswt_row_s;

  mswt_row_s   rows[8];
  logic [31:0] pat[3];

  mswt_upper dut (
    .clk_in                   (clk_in),
    .rst_in                   (rst_in),
    .reg_addr_in              (reg_addr_in),
    .reg_wdata_in             (reg_wdata_in),
    .reg_wr_in                (reg_wr_in),
    .reg_rd_in                (reg_rd_in),
    .reg_rdata_out            (reg_rdata_out),
    .lower_table_in           (lower_table_in),
    .segment_select_config_in (sel_in),
    .initial_sine_value_in    (sin_in),
    .initial_cosine_value_in  (cos_in),
    .microstep_counter_in     (cnt_in),
    .step_in                  (step_in),
    .step_dir_in              (dir_in),
    .coil_a_current_value_out (coil_a),
    .coil_b_current_value_out (coil_b)
  );

  initial clk_in = 1'b0;
  always #20 clk_in = ~clk_in;

  // ==========================================================
  // compare and bus tasks
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic check32(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check32

  task automatic check10(input string what, input mswt_pkg::mswt_cur_t exp,
                         input mswt_pkg::mswt_cur_t got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check10

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_rd_in    <= 1'b0;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
  endtask : reg_write

  // strobe is left high; a following bus_idle or access replaces it
  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
    reg_addr_in <= a;
    reg_wr_in   <= 1'b0;
    reg_rd_in   <= 1'b1;
    @(posedge clk_in);
    #1 check32("read data", exp, reg_rdata_out);
  endtask : reg_read

  task automatic bus_idle;
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    @(posedge clk_in);
  endtask : bus_idle

  function automatic int dlt(input logic [1:0] w, input logic b);
    return int'(w) - 1 + int'(b);
  endfunction : dlt

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      $display("MISMATCH timeout expected done seen running");
      conclude();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    int                  ma;
    int                  mb;
    mswt_pkg::mswt_cur_t ea;
    rows = '{'{2'h0, 2'h3, 1'b0, 1'b1, 1'b1}, '{2'h1, 2'h2, 1'b1, 1'b0, 1'b1},
             '{2'h2, 2'h1, 1'b0, 1'b0, 1'b0}, '{2'h3, 2'h0, 1'b1, 1'b1, 1'b0},
             '{2'h0, 2'h0, 1'b1, 1'b0, 1'b0}, '{2'h3, 2'h3, 1'b0, 1'b1, 1'b1},
             '{2'h1, 2'h1, 1'b0, 1'b1, 1'b0}, '{2'h2, 2'h2, 1'b1, 1'b0, 1'b1}};
    pat = '{32'ha5a50f0f, 32'h8000_0001, 32'h7ffffffe};
    rst_in = 1'b1; reg_addr_in = 8'h00; reg_wdata_in = 32'h0;
    reg_wr_in = 1'b0; reg_rd_in = 1'b0; lower_table_in = 160'h0;
    sel_in = 32'hffff8049; sin_in = 8'h40; cos_in = 8'hf7;
    cnt_in = 10'h000; step_in = 1'b0; dir_in = 1'b1;
    fails = 0; check_count = 0; cycles = 0;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    reg_read(`MSWT_ADDR_WORD5, `MSWT_RST_WORD5);
    reg_read(`MSWT_ADDR_WORD6, `MSWT_RST_WORD6);
    reg_read(`MSWT_ADDR_WORD7, `MSWT_RST_WORD7);
    for (int i = 0; i < 3; i++) reg_write(8'h65 + 8'(i), pat[i]);
    for (int i = 0; i < 3; i++) reg_read(8'h65 + 8'(i), pat[i]);
    // write then read back at once, no gap between the strobes
    reg_write(`MSWT_ADDR_WORD5, 32'h0f0f5a5a);
    reg_read(`MSWT_ADDR_WORD5, 32'h0f0f5a5a);
    bus_idle();
    #1 check32("read data idle", 32'h0, reg_rdata_out);
    reg_write(8'h68, 32'h12345678);
    reg_read(8'h68, 32'h0);
    reg_write(`MSWT_ADDR_COIL, 32'hffffffff);
    reg_read(`MSWT_ADDR_COIL, {6'h0, 10'h0f7, 6'h0, 10'h040});
    bus_idle();
    // one step from position zero per row, up or down
    foreach (rows[i]) begin
      reg_write(`MSWT_ADDR_WORD7, {rows[i].b_hi, 31'h0});
      bus_idle();
      sel_in <= {8'hc0, 8'ha0, 8'h80, rows[i].w_hi, 4'h5, rows[i].w_lo};
      lower_table_in <= {159'h0, rows[i].b_lo};
      cnt_in <= 10'h000;
      repeat (3) @(posedge clk_in);
      #1 check10("coil a load", 10'h040, coil_a);
      check10("coil b load", 10'h0f7, coil_b);
      step_in <= 1'b1;
      dir_in  <= rows[i].dir;
      @(posedge clk_in);
      step_in <= 1'b0;
      cnt_in  <= rows[i].dir ? 10'h001 : 10'h3ff;
      ma = 'h40 + dlt(rows[i].w_lo, rows[i].b_lo);
      mb = 'hf7 - dlt(rows[i].w_hi, rows[i].b_hi);
      ea = rows[i].dir ? mswt_pkg::mswt_cur_t'(ma) : -mswt_pkg::mswt_cur_t'(ma);
      #1 check10("coil a step", ea, coil_a);
      check10("coil b step", mswt_pkg::mswt_cur_t'(mb), coil_b);
      // stepping back onto position zero reloads the start values
      step_in <= 1'b1;
      dir_in  <= ~rows[i].dir;
      @(posedge clk_in);
      step_in <= 1'b0;
      cnt_in  <= 10'h000;
      #1 check10("coil a reload", 10'h040, coil_a);
      check10("coil b reload", 10'h0f7, coil_b);
    end
    // reset in mid-run brings back the default table
    rst_in <= 1'b1;
    @(posedge clk_in);
    rst_in <= 1'b0;
    reg_read(`MSWT_ADDR_WORD7, `MSWT_RST_WORD7);
    bus_idle();
    conclude();
  end
endmodule : testbench
